/* File: sac_pkg.sv */
// Package: register map, reset values, field positions and timing for the sequencer config block
package sac_pkg;
  // Printed offsets 0x22/0x23/0x24 are indices; byte address is four times the index
  localparam logic [7:0] SAC_IDX_SEQUENCER_CONTROL = 8'h22;
  localparam logic [7:0] SAC_IDX_AUTOCYCLE_CONTROL = 8'h23;
  localparam logic [7:0] SAC_IDX_CH_MASK = 8'h24;
  localparam logic [9:0] SAC_ADDR_SEQUENCER_CONTROL = {SAC_IDX_SEQUENCER_CONTROL, 2'b00};
  localparam logic [9:0] SAC_ADDR_AUTOCYCLE_CONTROL = {SAC_IDX_AUTOCYCLE_CONTROL, 2'b00};
  localparam logic [9:0] SAC_ADDR_CH_MASK = {SAC_IDX_CH_MASK, 2'b00};
  // Reset values
  localparam logic [7:0] SAC_SEQUENCER_CONTROL_RST = 8'h80;
  localparam logic [7:0] SAC_AUTOCYCLE_CONTROL_RST = 8'h00;
  localparam logic [15:0] SAC_CH_MASK_RST = 16'h0001;
  // Field positions
  localparam int SAC_STD_ON_BIT = 7;
  localparam int SAC_SELF_TIMED_CONVERT_ON_BIT = 0;
  localparam int SAC_SELF_TIMED_PERIOD_SELECT_LSB = 1;
  localparam logic [7:0] SAC_AC_WMASK = 8'h0F;
  // Autocycle periods in microseconds, codes 0..7, and clock rate
  localparam int SAC_CLK_MHZ = 125;
  localparam int SAC_PERIOD_US [8] = '{10, 20, 40, 80, 100, 200, 400, 800};
  localparam int SAC_CNT_W = 17;
endpackage : sac_pkg

/* File: sac_tick_if.sv */
// Interface: timer control from register bank to autocycle timer
`timescale 1ns/1ns
interface sac_tick_if;
  logic enable;
  logic [2:0] select;
  logic start;
  modport bank (output enable, output select, input start);
  modport timer (input enable, input select, output start);
endinterface : sac_tick_if

/* File: sac_timer.sv */
// Autocycle timer: emits a one-cycle conversion-start pulse at the selected period
`timescale 1ns/1ns
module sac_timer (
  input wire logic pclk,
  input wire logic presetn,
  sac_tick_if.timer tick
);
  typedef struct packed {
    logic [sac_pkg::SAC_CNT_W-1:0] count;
    logic start;
  } sac_timer_state_t;

  sac_timer_state_t state;
  sac_timer_state_t next_state;

  // Cycle count of one period; periods are exact multiples of the 8 ns clock
  function automatic logic [sac_pkg::SAC_CNT_W-1:0] sac_period_cycles(input logic [2:0] sel);
    sac_period_cycles = sac_pkg::SAC_CNT_W'(sac_pkg::SAC_PERIOD_US[sel] * sac_pkg::SAC_CLK_MHZ);
  endfunction : sac_period_cycles

  // Count up while enabled; disabling restarts the period from scratch
  always_comb begin
    next_state = state;
    next_state.start = 1'b0;
    if (!tick.enable) begin
      next_state.count = '0;
    end else if (state.count >= sac_period_cycles(tick.select) - 1'b1) begin
      next_state.count = '0;
      next_state.start = 1'b1;
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick.start = state.start;

  // No pulse while the mode is off
  property p_no_pulse_off;
    @(posedge pclk) disable iff (!presetn)
      !tick.enable |=> !state.start;
  endproperty
  a_no_pulse_off: assert property (p_no_pulse_off) else $error("pulse while autocycle off");

  // Fastest period: no pulse 8 cycles after a pulse when select stays 0
  property p_period_10us;
    @(posedge pclk) disable iff (!presetn)
      (state.start && tick.enable && tick.select == 3'h0) ##1
      (tick.enable && tick.select == 3'h0) [*8]
      |-> !state.start;
  endproperty
  a_period_10us: assert property (p_period_10us) else $error("autocycle pulse too early");

  property p_count_bound;
    @(posedge pclk) disable iff (!presetn)
      tick.enable |=> state.count < sac_period_cycles($past(tick.select));
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("timer count past period");

  c_pulse: cover property (@(posedge pclk) disable iff (!presetn) state.start);
endmodule : sac_timer

/* File: sac_config.sv */
// Top: APB register bank for sequencer control, autocycle control and channel mask
// Operation
// - Bit 7 enables standard sequencer, resets 0x80
// - Advanced slot count is field plus one
// - Autocycle pulse period chosen by 3-bit select
// - Bit 0 enables autocycle, register resets zero
// - Mask bit n includes input n
// - Channel mask resets to 0x0001
`timescale 1ns/1ns
module sac_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic standard_sequence_on,
  output logic [15:0] input_in_sequence,
  output logic [7:0] advanced_slot_total,
  output logic self_timed_convert_on,
  output logic [2:0] self_timed_period_select,
  output logic convert_start
);
  typedef struct packed {
    logic [7:0] sequencer_control;
    logic [7:0] autocycle_control;
    logic [15:0] standard_channel_mask;
    logic [31:0] rdata;
    logic slverr;
    logic start;
    logic ready;
    logic [7:0] slots;
  } sac_state_t;

  sac_state_t state;
  sac_state_t next_state;
  sac_tick_if tick ();

  // Register decode; only word-aligned addresses in the low 1 KiB are mapped
  function automatic logic [1:0] sac_decode(input logic [11:0] addr);
    if (addr[11:10] != 2'b00) begin
      sac_decode = 2'd3;
    end else if (addr[9:0] == sac_pkg::SAC_ADDR_SEQUENCER_CONTROL) begin
      sac_decode = 2'd0;
    end else if (addr[9:0] == sac_pkg::SAC_ADDR_AUTOCYCLE_CONTROL) begin
      sac_decode = 2'd1;
    end else if (addr[9:0] == sac_pkg::SAC_ADDR_CH_MASK) begin
      sac_decode = 2'd2;
    end else begin
      sac_decode = 2'd3;
    end
  endfunction : sac_decode

  logic access;
  logic [1:0] sel_reg;
  assign access = psel && penable;
  assign sel_reg = sac_decode(paddr);

  // Register writes, read data and error; zero-wait slave, answers in the access cycle
  always_comb begin
    next_state = state;
    next_state.start = tick.start;
    next_state.slverr = 1'b0;
    next_state.rdata = '0;
    if (psel && !penable) begin
      unique case (sel_reg)
        2'd0: next_state.rdata = {24'h000000, state.sequencer_control};
        2'd1: next_state.rdata = {24'h000000, state.autocycle_control & sac_pkg::SAC_AC_WMASK};
        2'd2: next_state.rdata = {16'h0000, state.standard_channel_mask};
        2'd3: next_state.slverr = 1'b1; // Unmapped: error answer, no effect
      endcase
      if (pwrite && sel_reg != 2'd3) begin
        next_state.rdata = '0;
      end
    end
    if (access && pwrite) begin
      unique case (sel_reg)
        2'd0: if (pstrb[0]) next_state.sequencer_control = pwdata[7:0];
        2'd1: if (pstrb[0]) next_state.autocycle_control = pwdata[7:0] & sac_pkg::SAC_AC_WMASK;
        2'd2: begin
          if (pstrb[0]) next_state.standard_channel_mask[7:0] = pwdata[7:0];
          if (pstrb[1]) next_state.standard_channel_mask[15:8] = pwdata[15:8];
        end
        2'd3: next_state.slverr = 1'b0;
      endcase
    end
    if (access) begin
      next_state.slverr = 1'b0;
    end
    // Zero-wait slave; ready is held in a flop so the port comes from a register
    next_state.ready = 1'b1;
    // Slot total kept registered alongside the field it follows
    next_state.slots = {1'b0, next_state.sequencer_control[6:0]} + 8'h01;
  end

  // Reset loads the documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.sequencer_control <= sac_pkg::SAC_SEQUENCER_CONTROL_RST;
      state.autocycle_control <= sac_pkg::SAC_AUTOCYCLE_CONTROL_RST;
      state.standard_channel_mask <= sac_pkg::SAC_CH_MASK_RST;
      state.rdata <= '0;
      state.slverr <= 1'b0;
      state.start <= 1'b0;
      state.ready <= 1'b0;
      state.slots <= 8'h01;
    end else begin
      state <= next_state;
    end
  end

  // Timer sees the stored fields directly
  assign tick.enable = state.autocycle_control[sac_pkg::SAC_SELF_TIMED_CONVERT_ON_BIT];
  assign tick.select = state.autocycle_control[sac_pkg::SAC_SELF_TIMED_PERIOD_SELECT_LSB +: 3];

  sac_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // Registered setup-phase capture gives data and error in the access cycle; pready low in reset, high from the first clock after it
  assign prdata = state.rdata;
  assign pslverr = state.slverr;
  assign pready = state.ready;
  // Outputs straight from the stored registers
  assign standard_sequence_on = state.sequencer_control[sac_pkg::SAC_STD_ON_BIT];
  assign input_in_sequence = state.standard_channel_mask;
  // Slot total widened to 8 bits so 127+1 fits; the host owns the zero-before-command-mode step
  assign advanced_slot_total = state.slots;
  assign self_timed_convert_on = tick.enable;
  assign self_timed_period_select = tick.select;
  assign convert_start = state.start;

  property p_reset_vals;
    @(posedge pclk) $rose(presetn) |-> state.sequencer_control == 8'h80 &&
      state.autocycle_control == 8'h00 && state.standard_channel_mask == 16'h0001;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_seq_write;
    @(posedge pclk) disable iff (!presetn)
      (access && pwrite && sel_reg == 2'd0 && pstrb[0]) |=>
        standard_sequence_on == $past(pwdata[7]);
  endproperty
  a_seq_write: assert property (p_seq_write) else $error("sequencer enable not written");

  property p_slots;
    @(posedge pclk) disable iff (!presetn)
      advanced_slot_total == 8'(state.sequencer_control[6:0]) + 8'h01;
  endproperty
  a_slots: assert property (p_slots) else $error("slot total wrong");

  property p_ac_write;
    @(posedge pclk) disable iff (!presetn)
      (access && pwrite && sel_reg == 2'd1 && pstrb[0]) |=>
        self_timed_convert_on == $past(pwdata[0]) && self_timed_period_select == $past(pwdata[3:1]);
  endproperty
  a_ac_write: assert property (p_ac_write) else $error("autocycle control not written");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn) state.autocycle_control[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      (access && pwrite && sel_reg == 2'd2 && pstrb == 4'hF) |=>
        input_in_sequence == $past(pwdata[15:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_mask_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_reg == 2'd2) |=>
        prdata == {16'h0000, input_in_sequence};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

  property p_start_when_on;
    @(posedge pclk) disable iff (!presetn) convert_start |-> $past(self_timed_convert_on, 2);
  endproperty
  a_start_when_on: assert property (p_start_when_on) else $error("start while off");

  c_write_mask: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && sel_reg == 2'd2);
  c_ac_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(self_timed_convert_on));
  c_err: cover property (@(posedge pclk) disable iff (!presetn) access && pslverr);
endmodule : sac_config

/* File: tb_sequencer_autocycle_config.sv */
// Testbench: self-checking APB bench for the sequencer and autocycle configuration bank
`timescale 1ns/1ns
module tb_sequencer_autocycle_config;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standard_sequence_on;
  logic [15:0] input_in_sequence;
  logic [7:0] advanced_slot_total;
  logic self_timed_convert_on;
  logic [2:0] self_timed_period_select;
  logic convert_start;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  sac_config i_sac_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standard_sequence_on(standard_sequence_on),
    .input_in_sequence(input_in_sequence), .advanced_slot_total(advanced_slot_total),
    .self_timed_convert_on(self_timed_convert_on),
    .self_timed_period_select(self_timed_period_select), .convert_start(convert_start)
  );

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // Hang guard: the timer scenarios need well under this many cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // Expected slot total and autocycle readback
  function automatic logic [31:0] f_slots(input logic [7:0] v);
    return 32'({1'b0, v[6:0]} + 8'h01);
  endfunction : f_slots

  function automatic logic [31:0] f_ac(input logic [7:0] v);
    return 32'(v & sac_pkg::SAC_AC_WMASK);
  endfunction : f_ac

  // Reset values seen at the outputs
  task automatic chk_reset();
    chk(32'(standard_sequence_on), 32'h00000001);
    chk(32'(self_timed_convert_on), 32'h00000000);
    chk(32'(input_in_sequence), 32'h00000001);
    chk(32'(convert_start), 32'h00000000);
  endtask : chk_reset

  initial begin
    logic [31:0] rd;
    logic er;
    logic [7:0] v;
    logic [15:0] m;
    int n;
    int per;
    void'($urandom(32'hdb90));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk_reset();
    apb(1'b0, sac_pkg::SAC_ADDR_SEQUENCER_CONTROL, 32'h0, 4'h0, rd, er);
    chk(rd, 32'(sac_pkg::SAC_SEQUENCER_CONTROL_RST));
    apb(1'b0, sac_pkg::SAC_ADDR_AUTOCYCLE_CONTROL, 32'h0, 4'h0, rd, er);
    chk(rd, 32'(sac_pkg::SAC_AUTOCYCLE_CONTROL_RST));
    apb(1'b0, sac_pkg::SAC_ADDR_CH_MASK, 32'h0, 4'h0, rd, er);
    chk(rd, 32'(sac_pkg::SAC_CH_MASK_RST));
    // Sequencer control: zero slot field first, then full field, then random
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      apb(1'b1, sac_pkg::SAC_ADDR_SEQUENCER_CONTROL, {24'($urandom), v}, 4'h1, rd, er);
      chk(32'(er), 32'h00000000);
      chk(32'(standard_sequence_on), 32'(v[7]));
      chk(32'(advanced_slot_total), f_slots(v));
      apb(1'b0, sac_pkg::SAC_ADDR_SEQUENCER_CONTROL, 32'h0, 4'h0, rd, er);
      chk(rd, 32'(v));
    end
    // Every period code, with random reserved bits that must be dropped
    for (int c = 0; c < 8; c++) begin
      v = {4'($urandom), 3'(c), 1'($urandom)};
      apb(1'b1, sac_pkg::SAC_ADDR_AUTOCYCLE_CONTROL, 32'(v), 4'h1, rd, er);
      chk(32'(self_timed_period_select), 32'(c));
      chk(32'(self_timed_convert_on), 32'(v[0]));
      apb(1'b0, sac_pkg::SAC_ADDR_AUTOCYCLE_CONTROL, 32'h0, 4'h0, rd, er);
      chk(rd, f_ac(v));
    end
    // Channel mask: all inputs, then random sets
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 16'hFFFF : 16'($urandom);
      apb(1'b1, sac_pkg::SAC_ADDR_CH_MASK, {16'($urandom), m}, 4'h3, rd, er);
      chk(32'(input_in_sequence), 32'(m));
    end
    // Low byte strobe only: the high byte keeps its value
    v = 8'($urandom);
    apb(1'b1, sac_pkg::SAC_ADDR_CH_MASK, {24'hFFFFFF, v}, 4'h1, rd, er);
    chk(32'(input_in_sequence), 32'({m[15:8], v}));
    m = {m[15:8], v};
    // Unmapped place: error, no data, no write
    apb(1'b0, 12'hC88, 32'h0, 4'h0, rd, er);
    chk({rd[30:0], er}, 32'h00000001);
    apb(1'b1, 12'hC90, 32'h0000FFFF, 4'h3, rd, er);
    chk(32'(er), 32'h00000001);
    chk(32'(input_in_sequence), 32'(m));
    // Pulse spacing for the two shortest periods
    for (int c = 0; c < 2; c++) begin
      per = sac_pkg::SAC_PERIOD_US[c] * sac_pkg::SAC_CLK_MHZ;
      apb(1'b1, sac_pkg::SAC_ADDR_AUTOCYCLE_CONTROL, 32'({3'(c), 1'b1}), 4'h1, rd, er);
      n = 0;
      while (convert_start !== 1'b1 && n < 3 * per) begin
        @(negedge pclk);
        n++;
      end
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (convert_start !== 1'b1 && n < 2 * per);
      chk(32'(n), 32'(per));
    end
    // Disabled: no pulse over more than one short period
    apb(1'b1, sac_pkg::SAC_ADDR_AUTOCYCLE_CONTROL, 32'h0000000E, 4'h1, rd, er);
    n = 0;
    repeat (1400) begin
      @(negedge pclk);
      if (convert_start !== 1'b0) n++;
    end
    chk(32'(n), 32'h00000000);
    // Second reset mid-run brings back the defaults, during and after it
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    chk_reset();
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk_reset();
    wrap_up();
  end
endmodule : tb_sequencer_autocycle_config
